/* logic/brf_core.sv */
// Purpose: fetch pointer, banked registers in data memory, status word
// Assumes: execution unit issues one write source per cycle
// Notes: stack pointer lives outside; its value arrives as stackAddr
// Function
// - Keep a 16-bit fetch pointer to the next instruction's location.
// - After reset load the pointer: high byte from FFFF, low from FFFE.
// - During execution the pointer equals the instruction address plus two.
// - Provide 1K bytes of data memory at 0040 to 043F.
// - Addresses 0000 to 00FF reachable by short direct addressing.
// - Sixteen banks of eight byte registers map onto 0040 to 00BF.
// - Registers and their memory bytes are one and the same storage.
// - Registers also form four 16-bit pairs, upper register high byte.
// - Pointer pair: plain, index plus displacement, base plus offset.
// - Pointer pair supports post-increment and pre-decrement.
// - Counter pair low register is base offset and divisor.
// - A 4-bit bank selector picks the bank; reset clears it.
// - Status word at 003F: bank in bits 3-0, flags in 7-4.
// - Status word reached by bank load, push, pop, memory access.
// - Memory write to status word changes bank only, sets jump flag.
// - Interrupt saves status word on stack; return restores it.
// - Up to fifteen interrupt sources, one bank each plus main.
// - Fetching from data memory raises address-trap reset, pin low.
module brf_core
	import brf_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	output logic             resetPinOut,
	output logic             resetPinOe,
	output logic             trapPulse,
	output logic [15:0]      progAddr,
	output logic             progRd,
	input  wire logic [7:0]  progData,
	output logic             coreRun,
	output logic [15:0]      fetchPointer,
	output logic [15:0]      instrAddr,
	input  wire logic [2:0]  pcStep,
	input  wire logic        pcLoad,
	input  wire logic [15:0] pcTarget,
	input  wire logic        memRd,
	input  wire logic        memWr,
	input  wire logic        memShort,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	output logic [7:0]       memRdData,
	output logic             memHit,
	input  wire brf_pair_t   pairSelA,
	output logic [15:0]      pairDataA,
	input  wire brf_pair_t   pairSelB,
	output logic [15:0]      pairDataB,
	input  wire logic        pairWr,
	input  wire brf_pair_t   pairWrSel,
	input  wire logic [1:0]  pairWrMask,
	input  wire logic [15:0] pairWrData,
	input  wire logic        agenReq,
	input  wire brf_amode_t  agenMode,
	input  wire logic [7:0]  agenDisp,
	output logic [15:0]      agenAddr,
	output logic [7:0]       divisor,
	input  wire logic        bankLoad,
	input  wire logic [3:0]  bankValue,
	input  wire logic        flagsWr,
	input  wire logic [3:0]  flagsValue,
	output logic [7:0]       statusWord,
	input  wire logic        intAccept,
	input  wire logic        pswPush,
	input  wire logic        pswPop,
	input  wire logic        intReturn,
	input  wire logic [15:0] stackAddr
);
	brf_state_t      state_r;
	brf_state_t      state_nxt;
	logic [15:0]     fp_r;
	logic [15:0]     fp_nxt;
	logic [15:0]     ia_r;
	logic [7:0]      vecHi_r;
	logic [15:0]     progAddr_r;
	logic [7:0]      trapCnt_r;
	logic [3:0]      bank_r;
	logic [3:0]      bank_nxt;
	logic [3:0]      flags_r;
	logic [3:0]      flags_nxt;
	logic [7:0]      memRdData_r;
	logic            memHit_r;
	logic [15:0]     pairA_r;
	logic [15:0]     pairB_r;
	logic [15:0]     agenAddr_r;
	logic [7:0]      divisor_r;
	logic [RAM_IDX_W-1:0] rdIdx  [RAM_RD_PORTS];
	logic [7:0]      rdData [RAM_RD_PORTS];

	// Address decode
	wire             run       = (state_r == ST_RUN);
	wire [15:0]      effAddr   = memShort ? {8'h00, memAddr[7:0]} : memAddr;
	wire             memInRam  = (effAddr >= RAM_BASE) && (effAddr <= RAM_LAST);
	wire             memIsStat = (effAddr == STATUS_ADDR);
	wire [15:0]      memOfs    = effAddr - RAM_BASE;
	wire [15:0]      stkOfs    = stackAddr - RAM_BASE;
	// Stack kept inside RAM and off the banks by software
	// stack placement
	wire             stkInRam  = (stackAddr > BANK_LAST) && (stackAddr <= RAM_LAST);
	wire [15:0]      iaOfs     = ia_r;
	wire             trapHit   = run && (iaOfs >= RAM_BASE) && (iaOfs <= RAM_LAST);

	// Bank n at 0040 + 8n: RAM index is bank, pair, byte
	// bank mapping
	wire [RAM_IDX_W-1:0] bankIdx = {3'b000, bank_r, 3'b000};
	wire [RAM_IDX_W-1:0] aLoIdx  = bankIdx | {7'h00, pairSelA, 1'b0};
	wire [RAM_IDX_W-1:0] bLoIdx  = bankIdx | {7'h00, pairSelB, 1'b0};
	wire [RAM_IDX_W-1:0] wLoIdx  = bankIdx | {7'h00, pairWrSel, 1'b0};
	wire [RAM_IDX_W-1:0] hlLoIdx = bankIdx | {7'h00, PAIR_PTR, 1'b0};
	wire [RAM_IDX_W-1:0] deLoIdx = bankIdx | {7'h00, PAIR_PTR2, 1'b0};
	wire [RAM_IDX_W-1:0] cIdx    = bankIdx | {7'h00, PAIR_CNT, 1'b0};

	assign rdIdx[0]  = memOfs[RAM_IDX_W-1:0];
	assign rdIdx[1]  = stkOfs[RAM_IDX_W-1:0];
	assign rdIdx[2]  = aLoIdx;
	assign rdIdx[3]  = aLoIdx | 10'h001;
	assign rdIdx[4]  = bLoIdx;
	assign rdIdx[5]  = bLoIdx | 10'h001;
	assign rdIdx[6]  = hlLoIdx;
	assign rdIdx[7]  = hlLoIdx | 10'h001;
	assign rdIdx[8]  = deLoIdx;
	assign rdIdx[9]  = deLoIdx | 10'h001;
	assign rdIdx[10] = cIdx;

	// upper register is the high byte
	wire [15:0] hlVal = {rdData[7], rdData[6]};
	wire [15:0] deVal = {rdData[9], rdData[8]};
	wire [7:0]  cVal  = rdData[10];

	wire        agenInc = agenMode == AM_POST_INC;
	wire        agenDec = agenMode == AM_PRE_DEC;
	wire [15:0] hlDec   = hlVal - 16'h0001;
	wire [15:0] hlInc   = hlVal + 16'h0001;
	wire [15:0] dispExt = {{8{agenDisp[7]}}, agenDisp};
	wire [15:0] agenEa  =
		(agenMode == AM_INDEX_PTR)  ? hlVal + dispExt :
		(agenMode == AM_BASE_REG)   ? hlVal + {8'h00, cVal} :
		(agenMode == AM_PLAIN_PTR2) ? deVal :
		agenDec                     ? hlDec : hlVal;
	wire [15:0] hlNew   = agenDec ? hlDec : hlInc;

	// Write arbitration: stack, memory, pointer update, pair
	// save status word
	wire stkWr    = (intAccept || pswPush) && stkInRam && run;
	wire ramWr    = memWr && memInRam && run;
	wire agenUpd  = agenReq && (agenInc || agenDec) && run;
	wire gntRam   = ramWr && !stkWr;
	wire gntAgen  = agenUpd && !stkWr && !ramWr;
	wire gntPair  = pairWr && run && !stkWr && !ramWr && !agenUpd;

	// one storage for memory and registers
	wire                 wrEnA   = stkWr || gntRam || gntAgen || (gntPair && pairWrMask[0]);
	wire [RAM_IDX_W-1:0] wrIdxA  = stkWr  ? rdIdx[1] :
	                               gntRam ? rdIdx[0] :
	                               gntAgen ? hlLoIdx : wLoIdx;
	wire [7:0]           wrDataA = stkWr  ? statusWord :
	                               gntRam ? memWrData :
	                               gntAgen ? hlNew[7:0] : pairWrData[7:0];
	wire                 wrEnB   = gntAgen || (gntPair && pairWrMask[1]);
	wire [RAM_IDX_W-1:0] wrIdxB  = gntAgen ? (hlLoIdx | 10'h001) : (wLoIdx | 10'h001);
	wire [7:0]           wrDataB = gntAgen ? hlNew[15:8] : pairWrData[15:8];

	brf_data_ram u_ram (
		.clk_sys (clk_sys),
		.wrEnA   (wrEnA),
		.wrIdxA  (wrIdxA),
		.wrDataA (wrDataA),
		.wrEnB   (wrEnB),
		.wrIdxB  (wrIdxB),
		.wrDataB (wrDataB),
		.rdIdx   (rdIdx),
		.rdData  (rdData)
	);

	// Status word; restore beats memory write beats bank load
	wire restore = (pswPop || intReturn) && stkInRam && run;
	wire statWr  = memWr && memIsStat && run;
	always_comb begin
		bank_nxt  = bank_r;
		flags_nxt = flags_r;
		if (flagsWr && run) begin
			flags_nxt = flagsValue;
		end
		if (state_r == ST_TRAP) begin
			bank_nxt  = BANK_RESET;
			flags_nxt = FLAGS_RESET;
		end else if (restore) begin
			bank_nxt  = rdData[1][3:0];
			flags_nxt = rdData[1][7:4];
		end else if (statWr) begin
			bank_nxt          = memWrData[3:0];
			flags_nxt[JF_BIT-4] = 1'b1;
		end else if (bankLoad && run) begin
			bank_nxt = bankValue;
		end
	end
	assign statusWord = {flags_r, bank_r};

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bank_r  <= BANK_RESET;
			flags_r <= FLAGS_RESET;
		end else begin
			bank_r  <= bank_nxt;
			flags_r <= flags_nxt;
		end
	end

	// Vector fetch, run and trap sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_VEC_HI:   state_nxt = ST_VEC_LO;
			ST_VEC_LO:   state_nxt = ST_VEC_DONE;
			ST_VEC_DONE: state_nxt = ST_RUN;
			ST_RUN: begin
				if (trapHit) begin
					state_nxt = ST_TRAP;
				end
			end
			ST_TRAP: begin
				if (trapCnt_r == 8'h01) begin
					state_nxt = ST_VEC_HI;
				end
			end
			default:     state_nxt = ST_VEC_HI;
		endcase
	end

	always_comb begin
		fp_nxt = fp_r;
		if (state_r == ST_VEC_DONE) begin
			fp_nxt = {vecHi_r, progData} + PREFETCH_OFS;
		end else if (run && !trapHit) begin
			if (pcLoad) begin
				fp_nxt = pcTarget + PREFETCH_OFS;
			end else begin
				fp_nxt = fp_r + {13'h0000, pcStep};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_VEC_HI;
			fp_r    <= 16'h0000;
			ia_r    <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			fp_r    <= fp_nxt;
			ia_r    <= fp_nxt - PREFETCH_OFS;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			progAddr_r <= VEC_HI_ADDR;
			vecHi_r    <= 8'h00;
		end else begin
			if (state_r == ST_VEC_HI) begin
				progAddr_r <= VEC_LO_ADDR;
			end else if (state_r == ST_VEC_LO) begin
				vecHi_r    <= progData;
				progAddr_r <= VEC_HI_ADDR;
			end
		end
	end

	// Trap holds the pin low a fixed time, then refetches the vector
	// trap hold
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trapCnt_r <= 8'h00;
		end else if (trapHit) begin
			trapCnt_r <= TRAP_HOLD_CYC;
		end else if (trapCnt_r != 8'h00) begin
			trapCnt_r <= trapCnt_r - 8'h01;
		end
	end

	// Registered reads; status byte shadows no RAM
	// memory read path
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			memRdData_r <= 8'h00;
			memHit_r    <= 1'b0;
		end else if (memRd && run) begin
			memRdData_r <= memIsStat ? statusWord : (memInRam ? rdData[0] : 8'h00);
			memHit_r    <= memIsStat || memInRam;
		end else begin
			memHit_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pairA_r    <= 16'h0000;
			pairB_r    <= 16'h0000;
			agenAddr_r <= 16'h0000;
			divisor_r  <= 8'h00;
		end else begin
			pairA_r   <= {rdData[3], rdData[2]};
			pairB_r   <= {rdData[5], rdData[4]};
			divisor_r <= cVal;
			if (agenReq && run) begin
				agenAddr_r <= agenEa;
			end
		end
	end

	assign progAddr     = progAddr_r;
	assign progRd       = (state_r == ST_VEC_HI) || (state_r == ST_VEC_LO);
	assign coreRun      = run;
	assign fetchPointer = fp_r;
	assign instrAddr    = ia_r;
	assign resetPinOut  = 1'b0;
	assign resetPinOe   = (state_r == ST_TRAP);
	assign trapPulse    = trapHit;
	assign memRdData    = memRdData_r;
	assign memHit       = memHit_r;
	assign pairDataA    = pairA_r;
	assign pairDataB    = pairB_r;
	assign agenAddr     = agenAddr_r;
	assign divisor      = divisor_r;

	// Checks; the release edge still samples reset-time state, so gate on reset_n
	vec_order_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reset_n && progRd && progAddr == VEC_HI_ADDR) |=> (progRd && progAddr == VEC_LO_ADDR))
		else $error("vector low byte not fetched after high byte");
	vec_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_r == ST_VEC_LO) ##1 (state_r == ST_VEC_DONE) |=>
		fetchPointer == {$past(progData, 2), $past(progData)} + PREFETCH_OFS)
		else $error("fetch pointer not loaded from vector word");
	prefetch_ofs_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		coreRun |-> fetchPointer == instrAddr + PREFETCH_OFS)
		else $error("fetch pointer not two ahead of instruction");
	jump_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(coreRun && pcLoad && !trapPulse) |=> fetchPointer == $past(pcTarget) + 16'h0002)
		else $error("jump target not loaded with prefetch offset");
	trap_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		trapPulse |=> (resetPinOe && !coreRun)[*8])
		else $error("address trap did not hold reset pin low");
	status_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(statWr && !restore) |=> (statusWord[3:0] == $past(memWrData[3:0])
		&& statusWord[JF_BIT] && statusWord[6:4] == $past(statusWord[6:4])))
		else $error("status write touched flags or missed bank");
	stack_save_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stkWr |-> (wrEnA && wrDataA == statusWord && wrIdxA == stkOfs[RAM_IDX_W-1:0]))
		else $error("status word not saved on interrupt");
	trap_bank_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(resetPinOe && $past(resetPinOe)) |-> statusWord == {FLAGS_RESET, BANK_RESET})
		else $error("trap reset left bank selector set");
	post_inc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(gntAgen && agenInc) |=> (agenAddr == $past(hlVal) && hlVal == $past(hlVal) + 16'h0001))
		else $error("post-increment address or update wrong");
	pre_dec_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(gntAgen && agenDec) |=> (agenAddr == $past(hlVal) - 16'h0001 && hlVal == agenAddr))
		else $error("pre-decrement address or update wrong");
endmodule

/* logic/brf_data_ram.sv */
// Purpose: 1K byte data memory, two write ports, many read ports
// Assumes: write port B lands after port A on the same index
// Notes: contents have no reset, as in the real array
module brf_data_ram
	import brf_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 wrEnA,
	input  wire logic [RAM_IDX_W-1:0] wrIdxA,
	input  wire logic [7:0]           wrDataA,
	input  wire logic                 wrEnB,
	input  wire logic [RAM_IDX_W-1:0] wrIdxB,
	input  wire logic [7:0]           wrDataB,
	input  wire logic [RAM_IDX_W-1:0] rdIdx  [RAM_RD_PORTS],
	output logic      [7:0]           rdData [RAM_RD_PORTS]
);
	logic [7:0] mem [RAM_DEPTH];

	always_ff @(posedge clk_sys) begin
		if (wrEnA) begin
			mem[wrIdxA] <= wrDataA;
		end
		if (wrEnB) begin
			mem[wrIdxB] <= wrDataB;
		end
	end

	// Reads are combinational so a pair is seen whole
	genvar gi;
	generate
		for (gi = 0; gi < RAM_RD_PORTS; gi++) begin : g_rd
			assign rdData[gi] = mem[rdIdx[gi]];
		end
	endgenerate
endmodule

/* logic/brf_pkg.sv */
// Purpose: constants and types of the banked register file core
// Assumes: 100 MHz clk_sys, byte data memory
// Notes: flags sit in the upper nibble of the status word
package brf_pkg;
	localparam logic [15:0] VEC_HI_ADDR   = 16'hFFFF;
	localparam logic [15:0] VEC_LO_ADDR   = 16'hFFFE;
	localparam logic [15:0] PREFETCH_OFS  = 16'h0002;
	localparam logic [15:0] RAM_BASE      = 16'h0040;
	localparam logic [15:0] RAM_LAST      = 16'h043F;
	localparam logic [15:0] SHORT_LAST    = 16'h00FF;
	localparam logic [15:0] BANK_LAST     = 16'h00BF;
	localparam logic [15:0] STATUS_ADDR   = 16'h003F;
	localparam int          RAM_DEPTH     = 1024;
	localparam int          RAM_IDX_W     = 10;
	localparam int          RAM_RD_PORTS  = 11;
	localparam int          NUM_BANKS     = 16;
	localparam int          NUM_INT_SRC   = 15;
	localparam int          JF_BIT        = 7;
	localparam int          ZF_BIT        = 6;
	localparam int          CF_BIT        = 5;
	localparam int          HF_BIT        = 4;
	localparam logic [3:0]  BANK_RESET    = 4'h0;
	localparam logic [3:0]  FLAGS_RESET   = 4'h8;
	localparam logic [7:0]  TRAP_HOLD_CYC = 8'h10;
	// Register pairs in bank order; low byte first in memory
	typedef enum logic [1:0] {
		PAIR_ACC,
		PAIR_CNT,
		PAIR_PTR2,
		PAIR_PTR
	} brf_pair_t;
	typedef enum logic [2:0] {
		AM_PLAIN_PTR,
		AM_INDEX_PTR,
		AM_BASE_REG,
		AM_PLAIN_PTR2,
		AM_POST_INC,
		AM_PRE_DEC
	} brf_amode_t;
	typedef enum logic [2:0] {
		ST_VEC_HI,
		ST_VEC_LO,
		ST_VEC_DONE,
		ST_RUN,
		ST_TRAP
	} brf_state_t;
endpackage

/* verification/banked_register_file_pc_bench.sv */
// Purpose: self-checking bench for the banked register file core
// Assumes: 100 MHz clock, program memory model on the vector side
// Notes: stack kept at 0100, away from the bank area
module banked_register_file_pc_bench
	import brf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] VEC = 16'hC03E;
	logic             clk_sys = 1'b0;
	logic             reset_n = 1'b0;
	logic             resetPinOut, resetPinOe, trapPulse, progRd, coreRun, memHit;
	logic [15:0]      progAddr, fetchPointer, instrAddr, pairDataA, pairDataB, agenAddr;
	logic [7:0]       progData, memRdData, divisor, statusWord;
	logic [2:0]       pcStep = 3'h0;
	logic             pcLoad = 1'b0, memRd = 1'b0, memWr = 1'b0, memShort = 1'b0;
	logic             pairWr = 1'b0, agenReq = 1'b0, bankLoad = 1'b0, flagsWr = 1'b0;
	logic             intAccept = 1'b0, pswPush = 1'b0, pswPop = 1'b0, intReturn = 1'b0;
	logic [15:0]      pcTarget = 16'h0000, memAddr = 16'h0000, pairWrData = 16'h0000;
	logic [15:0]      stackAddr = 16'h0100;
	logic [7:0]       memWrData = 8'h00, agenDisp = 8'h00;
	logic [3:0]       bankValue = 4'h0, flagsValue = 4'h0;
	logic [1:0]       pairWrMask = 2'h0;
	brf_pair_t        pairSelA = PAIR_ACC, pairSelB = PAIR_CNT, pairWrSel = PAIR_ACC;
	brf_amode_t       agenMode = AM_PLAIN_PTR;
	int               failures = 0;
	int               tests_run = 0;

	brf_core uut (.clk_sys, .reset_n, .resetPinOut, .resetPinOe, .trapPulse, .progAddr,
		.progRd, .progData, .coreRun, .fetchPointer, .instrAddr, .pcStep, .pcLoad, .pcTarget,
		.memRd, .memWr, .memShort, .memAddr, .memWrData, .memRdData, .memHit, .pairSelA,
		.pairDataA, .pairSelB, .pairDataB, .pairWr, .pairWrSel, .pairWrMask, .pairWrData,
		.agenReq, .agenMode, .agenDisp, .agenAddr, .divisor, .bankLoad, .bankValue, .flagsWr,
		.flagsValue, .statusWord, .intAccept, .pswPush, .pswPop, .intReturn, .stackAddr);
	brf_prog_mem #(.VECTOR(VEC)) prog (.clk_sys, .progRd, .progAddr, .progData);

	always #5 clk_sys = ~clk_sys;

	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task waitRun;
		int i;
		i = 0;
		while (coreRun !== 1'b1 && i < 100) begin
			cyc(1);
			i++;
		end
		chk(coreRun, 1'b1);
	endtask
	task memOp(input logic wr, input logic sh, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		memRd <= ~wr;
		memWr <= wr;
		memShort <= sh;
		memAddr <= a;
		memWrData <= d;
		@(posedge clk_sys);
		memRd <= 1'b0;
		memWr <= 1'b0;
		memShort <= 1'b0;
		#1;
	endtask
	task setBank(input logic [3:0] n);
		@(posedge clk_sys);
		bankLoad <= 1'b1;
		bankValue <= n;
		@(posedge clk_sys);
		bankLoad <= 1'b0;
		#1;
	endtask
	task setPair(input brf_pair_t s, input logic [15:0] v);
		@(posedge clk_sys);
		pairWr <= 1'b1;
		pairWrSel <= s;
		pairWrMask <= 2'h3;
		pairWrData <= v;
		@(posedge clk_sys);
		pairWr <= 1'b0;
		#1;
	endtask
	task jumpTo(input logic [15:0] t);
		@(posedge clk_sys);
		pcLoad <= 1'b1;
		pcTarget <= t;
		@(posedge clk_sys);
		pcLoad <= 1'b0;
		#1;
	endtask
	task stop_test;
		$display("Counts: %0d compares, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task test_reset;
		repeat (8) @(posedge clk_sys);
		#1;
		chk(statusWord, {FLAGS_RESET, BANK_RESET});
		chk(resetPinOe, 1'b0);
		@(posedge clk_sys);
		reset_n <= 1'b1;
		waitRun();
		chk(fetchPointer, VEC + PREFETCH_OFS);
		chk(instrAddr, VEC);
		$display("test reset done");
	endtask
	task test_pc;
		jumpTo(16'h8123);
		chk(fetchPointer, 16'h8125);
		chk(instrAddr, 16'h8123);
		@(posedge clk_sys);
		pcStep <= 3'h3;
		@(posedge clk_sys);
		pcStep <= 3'h0;
		cyc(1);
		chk(fetchPointer, 16'h8128);
		$display("test pc done");
	endtask
	task test_banks;
		logic [3:0]  bk [3];
		logic [15:0] v;
		bk = '{4'h0, 4'h7, 4'hF};
		foreach (bk[i]) begin
			v = {4'hA, bk[i], 4'h5, bk[i]};
			setBank(bk[i]);
			setPair(PAIR_ACC, v);
			cyc(2);
			chk(pairDataA, v);
			chk(statusWord[3:0], bk[i]);
			memOp(1'b0, 1'b0, RAM_BASE + 16'(bk[i]) * 16'h0008, 8'h00);
			chk(memRdData, v[7:0]);
			chk(memHit, 1'b1);
			memOp(1'b0, 1'b0, RAM_BASE + 16'(bk[i]) * 16'h0008 + 16'h0001, 8'h00);
			chk(memRdData, v[15:8]);
		end
		$display("test banks done");
	endtask
	task test_map;
		memOp(1'b1, 1'b0, RAM_LAST, 8'h5A);
		memOp(1'b0, 1'b0, RAM_LAST, 8'h00);
		chk(memRdData, 8'h5A);
		memOp(1'b0, 1'b0, RAM_LAST + 16'h0001, 8'h00);
		chk({memHit, memRdData}, 9'h000);
		memOp(1'b1, 1'b0, 16'h00D0, 8'hC3);
		memOp(1'b0, 1'b1, 16'h12D0, 8'h00);
		chk(memRdData, 8'hC3);
		$display("test map done");
	endtask
	task test_status;
		@(posedge clk_sys);
		flagsWr <= 1'b1;
		flagsValue <= 4'h6;
		@(posedge clk_sys);
		flagsWr <= 1'b0;
		cyc(1);
		chk(statusWord, 8'h6F);
		memOp(1'b1, 1'b0, STATUS_ADDR, 8'h35);
		cyc(1);
		chk(statusWord, 8'hE5);
		memOp(1'b0, 1'b0, STATUS_ADDR, 8'h00);
		chk(memRdData, 8'hE5);
		memOp(1'b1, 1'b0, STATUS_ADDR, memRdData + 8'h01);
		cyc(1);
		chk(statusWord, 8'hE6);
		$display("test status done");
	endtask
	task test_agen;
		logic [15:0] ex [6];
		ex = '{16'h0150, 16'h014E, 16'h0157, 16'h0200, 16'h0150, 16'h0150};
		setPair(PAIR_PTR, 16'h0150);
		setPair(PAIR_CNT, 16'h0007);
		setPair(PAIR_PTR2, 16'h0200);
		cyc(2);
		chk(divisor, 8'h07);
		chk(pairDataB, 16'h0007);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			agenReq <= 1'b1;
			agenMode <= brf_amode_t'(i);
			agenDisp <= 8'hFE;
			@(posedge clk_sys);
			agenReq <= 1'b0;
			#1;
			chk(agenAddr, ex[i]);
		end
		@(posedge clk_sys);
		pairSelB <= PAIR_PTR;
		cyc(2);
		chk(pairDataB, 16'h0150);
		$display("test agen done");
	endtask
	task test_stack;
		setBank(4'h9);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			intAccept <= (k == 0);
			pswPush <= (k == 1);
			@(posedge clk_sys);
			intAccept <= 1'b0;
			pswPush <= 1'b0;
			setBank(4'h3);
			chk(statusWord, 8'hE3);
			@(posedge clk_sys);
			intReturn <= (k == 0);
			pswPop <= (k == 1);
			@(posedge clk_sys);
			intReturn <= 1'b0;
			pswPop <= 1'b0;
			cyc(1);
			chk(statusWord, 8'hE9);
		end
		memOp(1'b0, 1'b0, stackAddr, 8'h00);
		chk(memRdData, 8'hE9);
		$display("test stack done");
	endtask
	task test_trap;
		logic [15:0] n;
		jumpTo(16'h0100);
		chk(trapPulse, 1'b1);
		n = 16'h0000;
		cyc(1);
		while (resetPinOe === 1'b1 && n < 16'h0040) begin
			chk({resetPinOut, coreRun}, 2'h0);
			n++;
			cyc(1);
		end
		chk(n, 16'(TRAP_HOLD_CYC));
		waitRun();
		chk(fetchPointer, VEC + PREFETCH_OFS);
		chk(statusWord, {FLAGS_RESET, BANK_RESET});
		$display("test trap done");
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		stop_test();
	end
	initial begin
		test_reset();
		test_pc();
		test_banks();
		test_map();
		test_status();
		test_agen();
		test_stack();
		test_trap();
		stop_test();
	end
endmodule

/* verification/brf_prog_mem.sv */
// Purpose: program memory model answering the vector fetch
// Assumes: byte answer one cycle after each read address
// Notes: off-read data toggles so stale bytes never look valid
module brf_prog_mem
	import brf_pkg::*;
#(
	parameter logic [15:0] VECTOR = 16'hC03E
)
(
	input  wire logic        clk_sys,
	input  wire logic        progRd,
	input  wire logic [15:0] progAddr,
	output logic      [7:0]  progData
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] romByte_r = 8'h5A;
	assign progData = romByte_r;
	always @(posedge clk_sys) begin
		if (progRd && progAddr == VEC_HI_ADDR)
			romByte_r <= VECTOR[15:8];
		else if (progRd && progAddr == VEC_LO_ADDR)
			romByte_r <= VECTOR[7:0];
		else
			romByte_r <= ~romByte_r;
	end
endmodule
